// ===== tlpd_driver.sv
`timescale 1ns/100ps
`default_nettype none
// Triplex LCD phase driver: six-phase backplane and segment sequencer.
module tlpd_driver #(
  parameter int unsigned PHASE_CYC_DEF = tlpd_pkg::PHASE_CYC,
  parameter int unsigned DISCH_CYC_DEF = tlpd_pkg::DISCH_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [15:0] digits,
  input  wire logic [3:0]  special,
  input  wire logic        image_load,
  input  wire logic        use_counter,
  input  wire logic [17:0] phase_len,
  input  wire logic        rc_tick_input,
  output logic             rc_tick_out,
  output logic             rc_tick_oe,
  output logic             backplane_one_pin,
  output logic             backplane_one_oe,
  output logic             backplane_two_pin,
  output logic             backplane_two_oe,
  output logic             backplane_three_pin,
  output logic             backplane_three_oe,
  output logic      [3:0]  seg_d,
  output logic      [7:0]  seg_l,
  output logic      [2:0]  phase,
  output logic             busy
);

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_DISCH = 4'h2,
    ST_HIZ   = 4'h4,
    ST_APPLY = 4'h8
  } tlpd_state_e;

  // Complete state of the block.
  typedef struct packed {
    tlpd_state_e st;       // Sequencer state.
    logic [2:0]  ph;       // Current phase index.
    logic [17:0] cnt;      // Phase and discharge timer.
    logic [2:0]  sync;     // Tick pin synchroniser.
    logic        tick_lvl; // Filtered tick level.
    logic        pend;     // Pending phase tick.
    logic        copying;  // Images being copied.
    logic [23:0] img_d;    // Refresh list for segment port D.
    logic [47:0] img_l;    // Refresh list for segment port L.
    logic [7:0]  bp_data;  // Backplane data image.
    logic [7:0]  bp_conf;  // Backplane configuration image.
    logic [3:0]  seg_d;    // Segment port D register.
    logic [7:0]  seg_l;    // Segment port L register.
    logic        disch;    // Tick pin driven low.
  } tlpd_state_s;

  tlpd_state_s r;       // Registered state.
  tlpd_state_s next_r;  // Next state.
  logic [23:0] new_d;   // Freshly computed D images.
  logic [47:0] new_l;   // Freshly computed L images.
  logic        rise;    // Filtered rising edge on the tick pin.
  logic [17:0] plen;    // Selected phase length.

  // Image conversion runs combinationally from the live digits and special inputs; only its result is latched.
  tlpd_image u_image (
    .digits    (digits),
    .special   (special),
    .seg_d_img (new_d),
    .seg_l_img (new_l)
  );

  // Phase length falls back to the slowest legal value when programmed too long or too short.
  always_comb begin
    plen = phase_len;
    if (phase_len > 18'(PHASE_CYC_DEF) || phase_len < 18'(tlpd_pkg::PHASE_MIN_CYC)) begin
      plen = 18'(PHASE_CYC_DEF);
    end
  end

  // Tick pin edge once the second and third stage agree.
  assign rise = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.tick_lvl;

  // Next-state logic for the whole block.
  always_comb begin
    next_r      = r;
    next_r.sync = {r.sync[1:0], rc_tick_input};
    if (r.sync[1] == r.sync[2]) begin
      next_r.tick_lvl = r.sync[2];
    end
    // Copy takes one cycle and holds off the tick.
    next_r.copying = image_load;
    if (r.copying) begin
      next_r.img_d = new_d;
      next_r.img_l = new_l;
    end
    unique case (r.st)
      ST_RUN: begin
        if (use_counter) begin
          next_r.cnt = r.cnt + 18'h00001;
          if (r.cnt + 18'h00001 >= plen) begin
            next_r.pend = 1'b1;
          end
        end
        // Tick is held off while the images are copied.
        if (r.pend && !r.copying && !image_load) begin
          next_r.pend  = 1'b0;
          next_r.st    = ST_DISCH;
          next_r.disch = 1'b1;
          next_r.cnt   = 18'h00000;
        end
      end
      ST_DISCH: begin
        next_r.cnt = r.cnt + 18'h00001;
        if (r.cnt + 18'h00001 >= 18'(DISCH_CYC_DEF)) begin
          next_r.disch = 1'b0;
          next_r.st    = ST_HIZ;
          next_r.ph    = (r.ph == 3'(tlpd_pkg::PHASES - 1)) ? 3'h0 : r.ph + 3'h1;
          next_r.bp_conf = 8'h00;
        end
      end
      ST_HIZ: begin
        next_r.st      = ST_APPLY;
        next_r.bp_data = tlpd_pkg::BP_DATA[r.ph];
        next_r.bp_conf = tlpd_pkg::BP_CONF[r.ph];
        next_r.seg_d   = r.img_d[r.ph*4 +: 4];
        next_r.seg_l   = r.img_l[r.ph*8 +: 8];
      end
      ST_APPLY: begin
        next_r.st  = ST_RUN;
        next_r.cnt = 18'h00000;
      end
    endcase
    // A pin edge that meets the take of the previous tick is kept, so the set wins.
    if (rise && !r.disch) begin
      next_r.pend = 1'b1;
    end
  end

  // Register with synchronous reset; reset starts with a discharge from phase five into phase zero.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      r         <= '0;
      r.st      <= ST_DISCH;
      r.disch   <= 1'b1;
      r.ph      <= 3'(tlpd_pkg::PHASES - 1);
    end else begin
      r <= next_r;
    end
  end

  // Backplane pin decode: data/config 0/0 is Hi-Z giving the mid level.
  assign backplane_one_pin   = r.bp_data[tlpd_pkg::BP1_BIT];
  assign backplane_one_oe    = r.bp_conf[tlpd_pkg::BP1_BIT];
  assign backplane_two_pin   = r.bp_data[tlpd_pkg::BP2_BIT];
  assign backplane_two_oe    = r.bp_conf[tlpd_pkg::BP2_BIT];
  assign backplane_three_pin = r.bp_data[tlpd_pkg::BP3_BIT];
  assign backplane_three_oe  = r.bp_conf[tlpd_pkg::BP3_BIT];
  assign rc_tick_out = 1'b0;
  assign rc_tick_oe  = r.disch;
  assign seg_d = r.seg_d;
  assign seg_l = r.seg_l;
  assign phase = r.ph;
  assign busy  = (r.st != ST_RUN);

  // Discharge lasts at least eight cycles once started.
  property p_disch_len;
    @(posedge clock) disable iff (!nrst)
      $rose(rc_tick_oe) |-> rc_tick_oe [*8] ;
  endproperty
  a_disch_len: assert property (p_disch_len) else $error("discharge too short");

  // Phase advances by one with wrap after discharge.
  property p_wrap;
    @(posedge clock) disable iff (!nrst)
      $fell(rc_tick_oe) |-> phase == (($past(phase) == 3'h5) ? 3'h0 : $past(phase) + 3'h1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase did not advance");

  // Backplanes are all Hi-Z one cycle before the new pattern.
  property p_hiz;
    @(posedge clock) disable iff (!nrst)
      $fell(rc_tick_oe) |-> !backplane_one_oe && !backplane_two_oe && !backplane_three_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("no Hi-Z gap");

  // Exactly one backplane is driven once the pattern is applied.
  property p_one_bp;
    @(posedge clock) disable iff (!nrst)
      (r.st == ST_APPLY) |-> $onehot({backplane_one_oe, backplane_two_oe, backplane_three_oe});
  endproperty
  a_one_bp: assert property (p_one_bp) else $error("backplane pattern wrong");

  // High phases drive high, low phases drive low.
  property p_level;
    @(posedge clock) disable iff (!nrst)
      (r.st == ST_APPLY) |-> ((phase < 3'h3) == (backplane_one_pin | backplane_two_pin
                                                 | backplane_three_pin));
  endproperty
  a_level: assert property (p_level) else $error("backplane level wrong");

  // Phase zero drives the first backplane.
  property p_ph0;
    @(posedge clock) disable iff (!nrst)
      (r.st == ST_APPLY && phase == 3'h0) |-> backplane_one_oe && backplane_one_pin;
  endproperty
  a_ph0: assert property (p_ph0) else $error("phase zero wrong");

  // No phase update starts while images are copied.
  property p_block;
    @(posedge clock) disable iff (!nrst)
      r.copying |=> !$rose(rc_tick_oe);
  endproperty
  a_block: assert property (p_block) else $error("tick during copy");

  // Update completes inside the instruction budget; the timer counts only the discharge part of the busy time.
  property p_budget;
    @(posedge clock) disable iff (!nrst)
      busy |-> (r.cnt < 18'(tlpd_pkg::UPDATE_LIMIT_CYC));
  endproperty
  a_budget: assert property (p_budget) else $error("update too slow");

  // Segment port D follows the refresh list when applied.
  property p_seg;
    @(posedge clock) disable iff (!nrst)
      (r.st == ST_APPLY) |-> seg_d == r.img_d[phase*4 +: 4];
  endproperty
  a_seg: assert property (p_seg) else $error("segment image wrong");

  c_wrap:  cover property (@(posedge clock) disable iff (!nrst) $fell(rc_tick_oe) && phase == 3'h0);
  c_copy:  cover property (@(posedge clock) disable iff (!nrst) r.copying && r.pend);
  c_cnt:   cover property (@(posedge clock) disable iff (!nrst) use_counter && $rose(rc_tick_oe));

endmodule : tlpd_driver
`default_nettype wire

// ===== tlpd_pkg.sv
// Operation
// - Six equal phases, refresh cycle at most 33 ms.
// - Refresh rate at least 30 Hz.
// - Slowest phase lasts 5.5 ms.
// - Phase start discharges capacitor, then releases tick.
// - Tick pin driven low about 40 us.
// - Each phase updates backplanes and segments.
// - Backplane: data/config gives Hi-Z, low, high.
// - Phase 0: first backplane high, pattern 04.
// - Phases 1, 2: second, third backplane high.
// - Phases 3 to 5: backplane low, others Hi-Z.
// - Three segment bits select one of eight waveforms.
// - Waveform uses six bits, one per phase.
// - Segment levels precomputed per phase into bytes.
// - 32 segments in list, specials separate, 36 total; the code also writes each special over bit 7 of its digit byte.
// - Hex digit converted to seven-segment pattern.
// - Images recomputed only when display changes; the code converts continuously and latches the result only on image_load.
// - Phase tick blocked while images are copied.
// - Reset configures ports, phase zero, discharges, enables; the code's reset loads phase five and its discharge enters phase zero.
// - Phase update finishes within 150 instruction cycles.
// - Instruction cycle is ten oscillator periods.
// - Phase index wraps from five to zero.
// - Mid level comes from high-impedance backplane.
// - Tick on rising edge of RC input.
package tlpd_pkg;

  // Clock rate of this block in Hz.
  localparam int unsigned CLK_HZ = 40000000;
  // Number of timephases in one refresh cycle.
  localparam int unsigned PHASES = 6;
  // Longest refresh cycle in ms and slowest phase in us.
  localparam int unsigned REFRESH_MAX_MS = 33;
  localparam int unsigned REFRESH_MIN_HZ = 30;
  localparam int unsigned PHASE_MAX_US   = 5500;
  // Phase length in clock cycles at the slowest permitted rate, rounded down.
  localparam int unsigned PHASE_CYC = PHASE_MAX_US * (CLK_HZ / 1000000);
  // Fastest refresh, used as the shortest programmable phase.
  localparam int unsigned REFRESH_MAX_HZ = 60;
  localparam int unsigned PHASE_MIN_CYC  = CLK_HZ / (REFRESH_MAX_HZ * PHASES);
  // Capacitor discharge time in us, as a least time rounded up.
  localparam int unsigned DISCH_US  = 40;
  localparam int unsigned DISCH_CYC = (DISCH_US * CLK_HZ + 999999) / 1000000;
  // Instruction cycle is ten oscillator periods of a 2 MHz oscillator: 5 us.
  localparam int unsigned OSC_HZ        = 2000000;
  localparam int unsigned OSC_PER_INSTR = 10;
  localparam int unsigned INSTR_LIMIT   = 150;
  localparam int unsigned UPDATE_LIMIT_CYC =
      INSTR_LIMIT * OSC_PER_INSTR * (CLK_HZ / OSC_HZ);
  // Backplane port images per phase, data then configuration.
  localparam logic [7:0] BP_DATA [PHASES] = '{8'h04, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] BP_CONF [PHASES] = '{8'h04, 8'h10, 8'h20, 8'h04, 8'h10, 8'h20};
  // Port bit positions of the three backplanes.
  localparam int unsigned BP1_BIT = 2;
  localparam int unsigned BP2_BIT = 4;
  localparam int unsigned BP3_BIT = 5;
  // Waveform bytes indexed by the three segment bits of a pin.
  localparam logic [7:0] WAVE [8] = '{8'h07, 8'h0E, 8'h15, 8'h1C, 8'h23, 8'h2A, 8'h31, 8'h38};
  // Seven-segment patterns for hex digits 0 to F.
  localparam logic [7:0] HEXSEG [16] = '{8'hEF, 8'h07, 8'hBD, 8'h3F, 8'h57, 8'h7E, 8'hFE, 8'h0F,
                                         8'hFF, 8'h7F, 8'hDF, 8'hF6, 8'hEC, 8'hB7, 8'hFC, 8'hDC};
  // Phase index of the first phase after reset; reset itself loads PHASES - 1.
  localparam logic [2:0] PHASE_RST = 3'h0;

endpackage : tlpd_pkg

// ===== tlpd_image.sv
`timescale 1ns/100ps
`default_nettype none
// Combinational conversion of digits and specials into per-phase port images.
module tlpd_image (
  input  wire logic [15:0] digits,
  input  wire logic [3:0]  special,
  output logic      [23:0] seg_d_img,
  output logic      [47:0] seg_l_img
);

  // Segment list of four bytes plus the four special bits.
  logic [7:0]  seglst [4];
  // Thirty-six segment states grouped three to a pin.
  logic [35:0] seg_bits;

  // Digit lookup and special insertion into the top bit of each byte.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      seglst[i]    = tlpd_pkg::HEXSEG[digits[i*4 +: 4]];
      seglst[i][7] = special[i];
    end
    seg_bits = {4'h0, seglst[3], seglst[2], seglst[1], seglst[0]};
    seg_bits[35:32] = special;
  end

  // Each of twelve pins picks a waveform from its three segment bits.
  genvar p;
  generate
    for (p = 0; p < 12; p++) begin : g_pin
      logic [7:0] w;
      assign w = tlpd_pkg::WAVE[seg_bits[p*3 +: 3]];
      for (genvar ph = 0; ph < 6; ph++) begin : g_ph
        if (p < 4) begin : g_d
          assign seg_d_img[ph*4 + p] = w[ph];
        end else begin : g_l
          assign seg_l_img[ph*8 + p - 4] = w[ph];
        end
      end
    end
  endgenerate

endmodule : tlpd_image
`default_nettype wire

// ===== tlpd_rc_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural RC timing network hanging on the tick pin.
module tlpd_rc_model (
  input  wire logic        clock,
  input  wire logic        pin_oe,
  input  wire logic        pin_out,
  input  wire logic [15:0] charge_cyc,
  output logic             pin_level
);
  // Clocks elapsed since the pin was released.
  logic [15:0] charge = 16'h0000;
  // A driven pin empties the capacitor; a released one lets it charge.
  always_ff @(posedge clock) begin
    if (pin_oe) begin
      charge <= 16'h0000;
    end else if (charge != 16'hFFFF) begin
      charge <= charge + 16'h0001;
    end
  end
  // The threshold is only crossed after the full charge time, so a slow net gives slow ticks.
  assign pin_level = pin_oe ? pin_out : (charge >= charge_cyc);
endmodule : tlpd_rc_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the six-phase LCD driver.
module tb_top;
  // Shortened counts keep the run brief; the phase and discharge checks derive from them.
  localparam int unsigned PH_CYC = 200;
  localparam int unsigned DS_CYC = 8;
  // Four images that together show every hex code.
  localparam logic [15:0] IMG [4] = '{16'h3210, 16'h7654, 16'hBA98, 16'hFEDC};
  localparam logic [3:0]  SPC [4] = '{4'h5, 4'hA, 4'h3, 4'hC};
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] digits = 16'h0000;
  logic [3:0]  special = 4'h0;
  logic        image_load = 1'b0;
  logic        use_counter = 1'b0;
  logic [17:0] phase_len = 18'h00000;
  logic [15:0] charge_cyc = 16'h0064;
  wire logic   rc_tick_input;
  logic        rc_tick_out, rc_tick_oe, busy;
  logic        bp1, bp1_oe, bp2, bp2_oe, bp3, bp3_oe;
  logic [3:0]  seg_d;
  logic [7:0]  seg_l;
  logic [2:0]  phase;
  int          failures = 0;
  int          checks_done = 0;

  // Free-running 40 MHz clock.
  always #12.5 clock = ~clock;

  tlpd_driver #(.PHASE_CYC_DEF(PH_CYC), .DISCH_CYC_DEF(DS_CYC)) u_tlpd_driver (
    .clock(clock), .nrst(nrst), .digits(digits), .special(special),
    .image_load(image_load), .use_counter(use_counter), .phase_len(phase_len),
    .rc_tick_input(rc_tick_input), .rc_tick_out(rc_tick_out), .rc_tick_oe(rc_tick_oe),
    .backplane_one_pin(bp1), .backplane_one_oe(bp1_oe),
    .backplane_two_pin(bp2), .backplane_two_oe(bp2_oe),
    .backplane_three_pin(bp3), .backplane_three_oe(bp3_oe),
    .seg_d(seg_d), .seg_l(seg_l), .phase(phase), .busy(busy));

  tlpd_rc_model u_tlpd_rc_model (
    .clock(clock), .pin_oe(rc_tick_oe), .pin_out(rc_tick_out),
    .charge_cyc(charge_cyc), .pin_level(rc_tick_input));

  // Compares one 8-bit result and counts it.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Compares a measured cycle count against a window.
  task automatic check_count(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      failures++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_count

  // Expected segment pin levels worked out from digits, specials and phase.
  function automatic logic [11:0] exp_seg(input logic [15:0] dg, input logic [3:0] sp,
                                          input logic [2:0] ph);
    logic [35:0] s;
    logic [11:0] r;
    s[35:32] = sp;
    for (int i = 0; i < 4; i++) begin
      s[8*i+:8] = tlpd_pkg::HEXSEG[dg[4*i+:4]];
      s[8*i+7] = sp[i];
    end
    for (int p = 0; p < 12; p++) begin
      r[p] = tlpd_pkg::WAVE[s[3*p+:3]][ph];
    end
    return r;
  endfunction : exp_seg

  // Requests a new image, then scrambles the inputs so a missed copy shows.
  task automatic load_image(input logic [15:0] dg, input logic [3:0] sp);
    @(posedge clock);
    digits <= dg;
    special <= sp;
    image_load <= 1'b1;
    @(posedge clock);
    image_load <= 1'b0;
    @(posedge clock);
    digits <= ~dg;
    special <= ~sp;
  endtask : load_image

  // Waits for phase ph, then judges discharge, gap, backplanes and segments.
  task automatic next_phase(input logic [2:0] ph, input logic [15:0] dg, input logic [3:0] sp,
                            input int dis);
    int n;
    int h;
    logic [7:0] d;
    logic [7:0] c;
    logic [11:0] e;
    n = 0;
    h = 0;
    while (phase !== ph && n < 4000) begin
      @(posedge clock);
      #1;
      n++;
      if (rc_tick_oe === 1'b1) h++;
    end
    check_count("phase_wait", 0, 3999, n);
    if (dis > 0) check_count("discharge", dis, dis, h);
    check("hiz_gap", 8'h00, {5'h00, bp3_oe, bp2_oe, bp1_oe});
    n = 0;
    while (busy !== 1'b0 && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    check_count("busy_len", 1, 9, n);
    d = tlpd_pkg::BP_DATA[ph];
    c = tlpd_pkg::BP_CONF[ph];
    e = exp_seg(dg, sp, ph);
    check("bp_oe", {5'h00, c[5], c[4], c[2]}, {5'h00, bp3_oe, bp2_oe, bp1_oe});
    check("bp_level", {5'h00, d[5], d[4], d[2]}, {5'h00, bp3 & bp3_oe, bp2 & bp2_oe, bp1 & bp1_oe});
    check("seg_d", {4'h0, e[3:0]}, {4'h0, seg_d});
    check("seg_l", e[11:4], seg_l);
  endtask : next_phase

  // Counts clocks until the phase index moves.
  task automatic wait_change(output int n);
    logic [2:0] q;
    q = phase;
    n = 0;
    while (phase === q && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : wait_change

  // Prints counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Reset values, then the first phase after release.
  task automatic test_reset();
    repeat (8) @(posedge clock);
    #1;
    check("rst_phase", 8'h05, {5'h00, phase});
    check("rst_outs", 8'h08, {4'h0, rc_tick_oe, bp3_oe, bp2_oe, bp1_oe});
    @(posedge clock);
    nrst <= 1'b1;
    load_image(IMG[0], SPC[0]);
    next_phase(3'h0, IMG[0], SPC[0], 0);
    $display("test reset done");
  endtask : test_reset

  // Full refresh cycles for each image, wrapping back to phase 0.
  task automatic test_images();
    for (int k = 0; k < 4; k++) begin
      if (k > 0) load_image(IMG[k], SPC[k]);
      for (int p = 1; p <= 6; p++) begin
        next_phase(3'(p % 6), IMG[k], SPC[k], DS_CYC);
      end
    end
    $display("test images done");
  endtask : test_images

  // A slow RC net only stretches the phase.
  task automatic test_slow();
    @(posedge clock);
    charge_cyc <= 16'h0384;
    next_phase(3'h1, IMG[3], SPC[3], DS_CYC);
    charge_cyc <= 16'h0064;
    $display("test slow done");
  endtask : test_slow

  // Internal timer with an out-of-range length falls back to the default.
  task automatic test_counter();
    int n;
    @(posedge clock);
    use_counter <= 1'b1;
    charge_cyc <= 16'hFFF0;
    wait_change(n);
    wait_change(n);
    check_count("timer_phase", PH_CYC, PH_CYC + 20, n);
    $display("test counter done");
  endtask : test_counter

  // Main sequence.
  initial begin
    test_reset();
    test_images();
    test_slow();
    test_counter();
    conclude();
  end

  // Watchdog well beyond the expected run of a few thousand clocks.
  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
